// File: core/adc_host_defs.svh
// timing constants and read-mode codes for the simultaneous-sampling converter host controller
`ifndef ADC_HOST_DEFS_SVH
`define ADC_HOST_DEFS_SVH

`define CLK_PERIOD_NS      10
// wake-up and start spacing figures in their own units
`define SLEEP_TO_RST_MS    50
`define RST_HIGH_NS        50
`define RST_TO_CONV_US     25
`define SLEEP_CTRL_TO_CONV_US    100
`define CYC_OVERLAP_NS     5000
`define CYC_SER2_NS        7000
`define CYC_SER1_NS        9700
// least times round up to whole cycles
`define SLEEP_TO_RST_CYC   ((`SLEEP_TO_RST_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_HIGH_CYC       ((`RST_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_TO_CONV_CYC    ((`RST_TO_CONV_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_CTRL_TO_CONV_CYC   ((`SLEEP_CTRL_TO_CONV_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_OVERLAP_CYC    ((`CYC_OVERLAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SER2_CYC       ((`CYC_SER2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SER1_CYC       ((`CYC_SER1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read strobe low and high phases, 15 ns least each
`define STROBE_NS          15
`define STROBE_CYC         ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read modes selecting the start spacing
`define MODE_OVERLAP       2'h0
`define MODE_SER2          2'h1
`define MODE_SER1          2'h2
`define CHANNELS           8

`endif

// File: core/adc_host_pkg.sv
// types for the converter host controller
package adc_host_pkg;
   typedef enum logic [3:0] {
      st_off    = 4'h0,
      st_sleep  = 4'h1,
      st_rst    = 4'h3,
      st_settle = 4'h2,
      st_idle   = 4'h6,
      st_start  = 4'h7,
      st_busy   = 4'h5,
      st_rlow   = 4'h4,
      st_rhigh  = 4'hc,
      st_space  = 4'hd
   } state_type;
endpackage

// File: core/sample_fifo.sv
// small flip-flop fifo for conversion results
`timescale 1ns/10ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("sample_fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   // pointers and fill level; full and empty come straight from the count
   always_comb begin
      push        = in_valid && (count != AW'(0) + (AW+1)'(DEPTH));
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage holds no reset; only written slots are ever read
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
endmodule // sample_fifo

// File: core/adc_host.sv
// host controller: wake-up, conversion starts and parallel result reads
//
// What this block does
// - after raising sleep control on a shutdown exit, wait 50 ms before raising reset.
// - hold reset high for at least 50 ns.
// - after reset falls, wait at least 25 us before raising either conversion start.
// - with reads during conversion, space conversion starts by at least 5 us.
// - with a two-line serial read after conversion, space starts by at least 7 us.
// - with a one-line serial read after conversion, space starts by at least 9.7 us.
// - after leaving standby, wait 100 us before a conversion start.
`timescale 1ns/10ps
`include "adc_host_defs.svh"
module adc_host #(
   parameter int unsigned SLEEP_TO_RST_CYC = `SLEEP_TO_RST_CYC,
   parameter int unsigned RST_TO_CONV_CYC  = `RST_TO_CONV_CYC,
   parameter int unsigned SLEEP_CTRL_TO_CONV_CYC = `SLEEP_CTRL_TO_CONV_CYC,
   parameter int          FIFO_DEPTH       = 4
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   // user side
   input  wire logic        power_up,
   input  wire logic        from_standby,
   input  wire logic        sample_req,
   input  wire logic [1:0]  read_mode,
   output logic             ready,
   output logic      [15:0] result,
   output logic             result_first,
   output logic             result_valid,
   input  wire logic        result_ready,
   // device pins
   output logic             sleep_ctrl,
   output logic             adc_reset,
   output logic             conv_start_a,
   output logic             conv_start_b,
   output logic             cs_rd_n,
   input  wire logic        busy,
   input  wire logic [15:0] parallel_bus,
   input  wire logic        first_channel_flag
);
   initial begin
      if (SLEEP_TO_RST_CYC < 1 || RST_TO_CONV_CYC < 1 || SLEEP_CTRL_TO_CONV_CYC < 1)
         $error("adc_host wait counts must be at least one cycle");
   end

   localparam logic [24:0] RST_HIGH    = 25'(`RST_HIGH_CYC);
   localparam logic [24:0] STROBE      = 25'(`STROBE_CYC);
   localparam logic [24:0] SPACE_OVL   = 25'(`CYC_OVERLAP_CYC);
   localparam logic [24:0] SPACE_SER2  = 25'(`CYC_SER2_CYC);
   localparam logic [24:0] SPACE_SER1  = 25'(`CYC_SER1_CYC);

   // start spacing for the selected read mode
   function automatic logic [24:0] spacing(input logic [1:0] m);
      unique case (m)
         `MODE_SER2: spacing = SPACE_SER2;
         `MODE_SER1: spacing = SPACE_SER1;
         default:    spacing = SPACE_OVL;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   adc_host_pkg::state_type state, next_state;
   logic [24:0] wait_cnt, next_wait_cnt;
   logic [24:0] gap_cnt, next_gap_cnt;
   logic [2:0]  chan, next_chan;
   logic [1:0]  mode, next_mode;
   logic        next_sleep_ctrl, next_adc_reset, next_conv, next_cs_rd_n, next_ready;
   logic        fifo_in_ready, fifo_out_valid, fifo_out_first;
   logic [15:0] fifo_out_data;
   logic        capture;

   // capture a word on the strobe's rising edge once the fifo has room
   assign capture = (state == adc_host_pkg::st_rlow) && (wait_cnt == '0) && fifo_in_ready;

   // sequencer: wake-up, start, wait out busy, read eight words, then space
   always_comb begin
      next_state      = state;
      next_wait_cnt   = (wait_cnt != '0) ? wait_cnt - 25'(1) : wait_cnt;
      next_gap_cnt    = (gap_cnt != '0) ? gap_cnt - 25'(1) : gap_cnt;
      next_chan       = chan;
      next_mode       = mode;
      next_sleep_ctrl = sleep_ctrl;
      next_adc_reset  = adc_reset;
      next_conv       = 1'b0;
      next_cs_rd_n    = cs_rd_n;
      next_ready      = 1'b0;
      unique case (state)
         adc_host_pkg::st_off: begin
            if (power_up) begin
               next_sleep_ctrl = 1'b1;
               if (from_standby) begin
                  next_wait_cnt = 25'(SLEEP_CTRL_TO_CONV_CYC - 1);
                  next_state    = adc_host_pkg::st_settle;
               end else begin
                  next_wait_cnt = 25'(SLEEP_TO_RST_CYC - 1);
                  next_state    = adc_host_pkg::st_sleep;
               end
            end
         end
         adc_host_pkg::st_sleep: begin
            if (wait_cnt == '0) begin
               next_adc_reset = 1'b1;
               next_wait_cnt  = RST_HIGH - 25'(1);
               next_state     = adc_host_pkg::st_rst;
            end
         end
         adc_host_pkg::st_rst: begin
            if (wait_cnt == '0) begin
               next_adc_reset = 1'b0;
               next_wait_cnt  = 25'(RST_TO_CONV_CYC - 1);
               next_state     = adc_host_pkg::st_settle;
            end
         end
         adc_host_pkg::st_settle: begin
            if (wait_cnt == '0) begin
               next_state = adc_host_pkg::st_idle;
            end
         end
         adc_host_pkg::st_idle: begin
            next_ready = !busy && (gap_cnt == '0);
            if (sample_req && ready) begin
               next_ready = 1'b0;
               next_conv  = 1'b1;
               next_mode  = read_mode;
               next_gap_cnt = spacing(read_mode) - 25'(1);
               next_state = adc_host_pkg::st_start;
            end
         end
         adc_host_pkg::st_start: begin
            // both starts rise together; device raises busy shortly after
            next_conv  = 1'b1;
            next_state = adc_host_pkg::st_busy;
         end
         adc_host_pkg::st_busy: begin
            // results valid only after busy falls
            next_conv = 1'b1;
            if (!busy && gap_cnt < spacing(mode) - 25'(2)) begin
               next_cs_rd_n  = 1'b0;
               next_chan     = '0;
               next_wait_cnt = STROBE;
               next_state    = adc_host_pkg::st_rlow;
            end
         end
         adc_host_pkg::st_rlow: begin
            // one word per strobe low, sampled at its end
            if (capture) begin
               next_cs_rd_n  = 1'b1;
               next_wait_cnt = STROBE - 25'(1);
               next_state    = adc_host_pkg::st_rhigh;
            end
         end
         adc_host_pkg::st_rhigh: begin
            if (wait_cnt == '0) begin
               if (chan == 3'(`CHANNELS - 1)) begin
                  next_state = adc_host_pkg::st_space;
               end else begin
                  next_chan     = chan + 3'(1);
                  next_cs_rd_n  = 1'b0;
                  next_wait_cnt = STROBE;
                  next_state    = adc_host_pkg::st_rlow;
               end
            end
         end
         adc_host_pkg::st_space: begin
            next_state = adc_host_pkg::st_idle;
         end
         default: begin
            next_state = adc_host_pkg::st_off;
         end
      endcase
      if (!power_up) begin
         next_state      = adc_host_pkg::st_off;
         next_sleep_ctrl = 1'b0;
         next_adc_reset  = 1'b0;
         next_conv       = 1'b0;
         next_cs_rd_n    = 1'b1;
         next_ready      = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state        <= adc_host_pkg::st_off;
         wait_cnt     <= '0;
         gap_cnt      <= '0;
         chan         <= '0;
         mode         <= `MODE_OVERLAP;
         sleep_ctrl   <= 1'b0;
         adc_reset    <= 1'b0;
         conv_start_a <= 1'b0;
         conv_start_b <= 1'b0;
         cs_rd_n      <= 1'b1;
         ready        <= 1'b0;
      end else begin
         state        <= next_state;
         wait_cnt     <= next_wait_cnt;
         gap_cnt      <= next_gap_cnt;
         chan         <= next_chan;
         mode         <= next_mode;
         sleep_ctrl   <= next_sleep_ctrl;
         adc_reset    <= next_adc_reset;
         conv_start_a <= next_conv;
         conv_start_b <= next_conv;
         cs_rd_n      <= next_cs_rd_n;
         ready        <= next_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result buffer; a stalled consumer holds the strobe low until room appears
   sample_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_data   ({first_channel_flag, parallel_bus}),
      .in_valid  (capture),
      .in_ready  (fifo_in_ready),
      .out_data  ({fifo_out_first, fifo_out_data}),
      .out_valid (fifo_out_valid),
      .out_ready (!result_valid || result_ready)
   );

   // output register stage so user outputs come from flip-flops
   logic [15:0] next_result;
   logic        next_result_first, next_result_valid;
   always_comb begin
      next_result       = result;
      next_result_first = result_first;
      next_result_valid = result_valid && !result_ready;
      if (fifo_out_valid && (!result_valid || result_ready)) begin
         next_result       = fifo_out_data;
         next_result_first = fifo_out_first;
         next_result_valid = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         result       <= '0;
         result_first <= 1'b0;
         result_valid <= 1'b0;
      end else begin
         result       <= next_result;
         result_first <= next_result_first;
         result_valid <= next_result_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset pulse width
   chk_reset_width: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(adc_reset) |-> adc_reset [*5]) else $error("reset pulse too short");

   chk_start_busy: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(conv_start_a) |-> $past(!busy)) else $error("start raised while busy");

   logic [24:0] since_start;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) since_start <= 25'h1ffffff;
      else if ($rose(conv_start_a)) since_start <= '0;
      else if (since_start != 25'h1ffffff) since_start <= since_start + 25'(1);
   end
   chk_start_space: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(conv_start_a) |-> $past(since_start) >= SPACE_OVL - 25'(1)) else $error("starts too close");

   sequence reset_release;
      $fell(adc_reset);
   endsequence
   chk_settle_wait: assert property (@(posedge mclk) disable iff (!nrst)
      reset_release |-> !conv_start_a [*8]) else $error("start too soon after reset");

   chk_strobe_high: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(cs_rd_n) |-> cs_rd_n [*2]) else $error("strobe high too short");

   // strobe low phase at least two cycles
   chk_strobe_low: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(cs_rd_n) |-> !cs_rd_n [*2]) else $error("strobe low too short");

   // reads only after busy has fallen
   chk_read_idle: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(cs_rd_n) && state == adc_host_pkg::st_rlow && chan == '0 |-> $past(!busy))
      else $error("read started during busy");

   chk_sleep_lead: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(adc_reset) |-> sleep_ctrl && $past(sleep_ctrl, 2)) else $error("reset before sleep exit");
endmodule // adc_host

// File: tb/adc_device_model.sv
// behavioural model of the eight-channel sampling converter seen from its host
`timescale 1ns/10ps
module adc_device_model #(
   parameter int CONV_NS = 3800
) (
   input  wire logic        conv_start_a,
   input  wire logic        conv_start_b,
   input  wire logic        adc_reset,
   input  wire logic        cs_rd_n,
   input  wire logic [15:0] base,
   output logic             busy,
   output logic      [15:0] parallel_bus,
   output logic             first_channel_flag
);
   logic [15:0] words [8];
   int          ch;

   // quiet levels at time zero, never unknown
   initial begin
      busy = 1'b0;
      parallel_bus = 16'h5a5a;
      first_channel_flag = 1'b1;
      ch = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start on later edge
   always @(posedge (conv_start_a & conv_start_b)) begin
      #12 busy = 1'b1; // kept off the host's clock edge, still inside 15 ns
      #(CONV_NS);
      foreach (words[i]) words[i] = base + 16'(i);
      ch = 0;
      busy = 1'b0;
   end

   // a reset pulse rewinds the channel pointer
   always @(posedge adc_reset) begin
      ch = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus driven after select
   always @(negedge cs_rd_n) begin
      #8 parallel_bus = words[ch % 8];
      first_channel_flag = (ch % 8 == 0);
   end

   // flag released on rise
   // released lines show the inverse, so a late capture is caught
   always @(posedge cs_rd_n) begin
      ch = ch + 1;
      #5 first_channel_flag = ~first_channel_flag;
      parallel_bus = ~parallel_bus;
   end
endmodule // adc_device_model

// File: tb/adc_host_tb.sv
// self-checking bench for the converter host controller with its device model
`timescale 1ns/10ps
`include "adc_host_defs.svh"
module adc_host_tb;
   localparam int SL = 20;
   localparam int RC = 10;
   localparam int SB = 20;
   logic        mclk, nrst, power_up, from_standby, sample_req, result_ready;
   logic        ready, result_first, result_valid, sleep_ctrl, adc_reset;
   logic        conv_start_a, conv_start_b, cs_rd_n, busy, first_channel_flag;
   logic [1:0]  read_mode, acc_mode, prev_mode;
   logic [15:0] result, parallel_bus, base;
   logic        hold, first_st, sleep_ctrl_exit, prev_sl, prev_rst, prev_cs, prev_busy;
   logic [16:0] exp_q [$];
   int          fail_count, n_tests, seed, cyc, n_conv, t_sleep, t_rrise, t_rfall, t_start;

   adc_host #(.SLEEP_TO_RST_CYC(SL), .RST_TO_CONV_CYC(RC), .SLEEP_CTRL_TO_CONV_CYC(SB), .FIFO_DEPTH(4)) dut (
      .mclk(mclk), .nrst(nrst), .power_up(power_up), .from_standby(from_standby), .sample_req(sample_req),
      .read_mode(read_mode), .ready(ready), .result(result), .result_first(result_first),
      .result_valid(result_valid), .result_ready(result_ready), .sleep_ctrl(sleep_ctrl),
      .adc_reset(adc_reset), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b), .cs_rd_n(cs_rd_n),
      .busy(busy), .parallel_bus(parallel_bus), .first_channel_flag(first_channel_flag));

   adc_device_model #(.CONV_NS(3800)) device (
      .conv_start_a(conv_start_a), .conv_start_b(conv_start_b), .adc_reset(adc_reset), .cs_rd_n(cs_rd_n),
      .base(base), .busy(busy), .parallel_bus(parallel_bus), .first_channel_flag(first_channel_flag));

   ////////////////////////////////////////////////////////////////////////////////
   // comparison and closing report
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // least start spacing, in cycles, for the mode of the previous conversion
   function automatic int min_gap(input logic [1:0] m);
      case (m)
         2'h0:    return `CYC_OVERLAP_CYC;
         2'h1:    return `CYC_SER2_CYC;
         default: return `CYC_SER1_CYC;
      endcase
   endfunction

   // word and first-channel flag the host should hand on
   function automatic logic [16:0] exp_word(input logic [15:0] b, input int c);
      return {c == 0, b + 16'(c)};
   endfunction

   task automatic wait_conv(input int n);
      while (n_conv < n) @(posedge mclk);
      #1;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin monitor: wake-up delays and start spacing, with the timeout
   always @(posedge mclk) begin
      logic [15:0] nb;
      cyc++;
      if (cyc >= 40000) begin
         fail_count++;
         results();
      end
      if (sample_req && ready) acc_mode = read_mode;
      if (sleep_ctrl && !prev_sl) begin
         t_sleep = cyc;
         sleep_ctrl_exit = from_standby;
         first_st = 1'b1;
      end
      if (adc_reset && !prev_rst) begin
         t_rrise = cyc;
         check("sleep_to_reset", (cyc - t_sleep >= SL) && !sleep_ctrl_exit, 1'b1);
      end
      if (!adc_reset && prev_rst) begin
         t_rfall = cyc;
         check("reset_high", cyc - t_rrise >= `RST_HIGH_CYC, 1'b1);
      end
      if (conv_start_a && !prev_cs) begin
         // busy as seen on the edge that launched the start, not the one that shows it
         check("start_while_busy", prev_busy, 1'b0);
         if (first_st && sleep_ctrl_exit)
            check("standby_to_start", cyc - t_sleep >= SB, 1'b1);
         else if (first_st)
            check("reset_to_start", cyc - t_rfall >= RC, 1'b1);
         else
            check("start_spacing", cyc - t_start >= min_gap(prev_mode), 1'b1);
         first_st = 1'b0;
         t_start = cyc;
         prev_mode = acc_mode;
         n_conv++;
         nb = 16'($random(seed));
         for (int c = 0; c < `CHANNELS; c++) exp_q.push_back(exp_word(nb, c));
         base <= #1 nb;
         read_mode <= #1 2'($unsigned($random(seed)) % 3);
      end
      prev_sl = sleep_ctrl;
      prev_rst = adc_reset;
      prev_cs = conv_start_a;
      prev_busy = busy;
   end

   // consumer with random stalls; hold keeps it stalled so the fifo fills
   always @(posedge mclk) begin
      if (result_valid && result_ready) begin
         check("word_expected", exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0)
            check("word", {result_first, result}, exp_q.pop_front());
      end
      result_ready <= #1 !hold && 1'($random(seed));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      nrst = 1'b0;
      {power_up, from_standby, sample_req, result_ready, hold} = 5'h00;
      {prev_sl, prev_rst, prev_cs, prev_busy, first_st, sleep_ctrl_exit} = 6'h00;
      read_mode = 2'h0;
      acc_mode = 2'h0;
      prev_mode = 2'h0;
      base = 16'h0000;
      seed = 16;
      repeat (15) @(posedge mclk);
      #1;
      check("reset_outputs", {ready, result_valid, sleep_ctrl, adc_reset, conv_start_a, cs_rd_n}, 6'h01);
      @(posedge mclk);
      #1 nrst = 1'b1;
      power_up = 1'b1;
      sample_req = 1'b1;
      wait_conv(4);
      // long stall: eight words cannot fit, strobes must wait without loss
      hold = 1'b1;
      repeat (1500) @(posedge mclk);
      #1 hold = 1'b0;
      wait_conv(6);
      sample_req = 1'b0;
      while (exp_q.size() != 0 || busy) @(posedge mclk);
      #1 power_up = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      check("off_pins", {sleep_ctrl, adc_reset, conv_start_a, conv_start_b, cs_rd_n}, 5'h01);
      from_standby = 1'b1;
      power_up = 1'b1;
      sample_req = 1'b1;
      wait_conv(n_conv + 3);
      sample_req = 1'b0;
      repeat (2000) @(posedge mclk);
      check("words_left", exp_q.size(), 32'h0);
      check("conversions", n_conv >= 9, 1'b1);
      results();
   end
endmodule // adc_host_tb
